// ==== bench/ide_host_port_signaling_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module ide_host_port_signaling_bench;
  logic i_clk_sys = 1'b0, i_clk_link = 1'b0, i_rst = 1'b1, i_cmd_valid = 1'b0, i_pause = 1'b0;
  ihps_pkg::ihps_cmd_t i_cmd = '0;
  ihps_pkg::ihps_word_t o_rd_word;
  logic o_cmd_ready, o_done, o_rd_valid, o_native_mode, o_drive_data_oe, i_channel_ready_in;
  logic o_drive_cmd_block_select_n, o_drive_ctrl_block_select_n, o_drive_ctrl_block_select_oe;
  logic o_primary_write_strobe_n, o_secondary_write_strobe_n, o_primary_read_strobe_n;
  logic o_secondary_read_strobe_n, o_primary_dma_ack_n, o_secondary_dma_ack_n;
  logic i_primary_dma_request, i_secondary_dma_request, i_drive_ctrl_block_select_n;
  logic [15:0] i_drive_data, o_drive_data, mdd, wd;
  logic [7:0] wn, dw;
  logic [1:0] req, sel, mode = 2'h0;
  logic strap = 1'b1, chan = 1'b0, want = 1'b0;
  int err_count = 0, n_tests = 0, cyc = 0, nrd;
  // the pin falls back to its strap resistor whenever the port lets go
  assign i_drive_ctrl_block_select_n = o_drive_ctrl_block_select_oe ?
    o_drive_ctrl_block_select_n : strap;
  assign i_drive_data = o_drive_data_oe ? o_drive_data : mdd;
  assign {i_secondary_dma_request, i_primary_dma_request} = req;
  ihps_host_port DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_clk_link(i_clk_link),
    .i_cmd(i_cmd), .i_cmd_valid(i_cmd_valid), .o_cmd_ready(o_cmd_ready), .i_pause(i_pause),
    .o_done(o_done), .o_rd_word(o_rd_word), .o_rd_valid(o_rd_valid),
    .o_native_mode(o_native_mode),
    .o_drive_cmd_block_select_n(o_drive_cmd_block_select_n),
    .o_drive_ctrl_block_select_n(o_drive_ctrl_block_select_n),
    .o_drive_ctrl_block_select_oe(o_drive_ctrl_block_select_oe),
    .i_drive_ctrl_block_select_n(i_drive_ctrl_block_select_n),
    .o_primary_write_strobe_n(o_primary_write_strobe_n),
    .o_secondary_write_strobe_n(o_secondary_write_strobe_n),
    .o_primary_read_strobe_n(o_primary_read_strobe_n),
    .o_secondary_read_strobe_n(o_secondary_read_strobe_n),
    .i_primary_dma_request(i_primary_dma_request),
    .i_secondary_dma_request(i_secondary_dma_request),
    .o_primary_dma_ack_n(o_primary_dma_ack_n),
    .o_secondary_dma_ack_n(o_secondary_dma_ack_n),
    .i_channel_ready_in(i_channel_ready_in), .i_drive_data(i_drive_data),
    .o_drive_data(o_drive_data), .o_drive_data_oe(o_drive_data_oe));
  ihps_drive_model m (.i_clk(i_clk_link), .i_chan(chan), .i_mode(mode), .i_want(want),
    .i_pins(chan ? {o_secondary_write_strobe_n, o_secondary_read_strobe_n,
      o_secondary_dma_ack_n, o_drive_cmd_block_select_n & o_drive_ctrl_block_select_n}
    : {o_primary_write_strobe_n, o_primary_read_strobe_n, o_primary_dma_ack_n,
      o_drive_cmd_block_select_n & o_drive_ctrl_block_select_n}),
    .i_dd(i_drive_data), .o_req(req), .o_rdy(i_channel_ready_in), .o_dd(mdd), .o_wd(wd),
    .o_wn(wn));
  initial forever #12.5 i_clk_sys = ~i_clk_sys;
  initial begin
    #7;
    forever #40 i_clk_link = ~i_clk_link;
  end
  task automatic final_report;
    $display("mismatches %0d, checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      final_report;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic do_reset(input logic s);
    int k;
    @(posedge i_clk_sys);
    strap <= s;
    i_rst <= 1'b1;
    repeat (10) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    for (k = 0; k < 99 && o_cmd_ready !== 1'b1; k++)
      @(negedge i_clk_sys);
    check(o_native_mode, s);
    check(o_drive_ctrl_block_select_oe, 1'b0);
  endtask : do_reset
  task automatic run(input logic c, input ihps_pkg::ihps_op_t op, input logic b,
    input logic [7:0] n);
    int k;
    logic [7:0] w0;
    @(posedge i_clk_sys);
    w0 = wn;
    nrd = 0;
    sel = 2'h3;
    chan <= c;
    mode <= op == ihps_pkg::IHPS_UD_RD ? 2'h1 : op == ihps_pkg::IHPS_UD_WR ? 2'h2 : 2'h0;
    i_cmd <= '{c, op, b, n, 16'h5a00 | {8'h0, n}};
    i_cmd_valid <= 1'b1;
    for (k = 0; k < 99 && o_cmd_ready !== 1'b1; k++)
      @(negedge i_clk_sys);
    @(posedge i_clk_sys);
    i_cmd_valid <= 1'b0;
    if (!want) begin
      repeat (60) @(negedge i_clk_sys);
      check({o_primary_dma_ack_n, o_secondary_dma_ack_n}, 2'h3);
      @(posedge i_clk_sys);
      want <= 1'b1;
    end
    for (k = 0; k < 3000 && o_done !== 1'b1; k++) begin
      @(negedge i_clk_sys);
      nrd += o_rd_valid;
      sel &= {o_drive_cmd_block_select_n, o_drive_ctrl_block_select_n};
    end
    check(k < 3000, 1'b1);
    dw = wn - w0;
  endtask : run
  task automatic pio_wr;
    run(1'b0, ihps_pkg::IHPS_PIO_WR, 1'b0, 8'h1);
    check(sel, 2'h1);
    check({dw, wd}, 24'h015a01);
  endtask : pio_wr
  task automatic pio_rd;
    run(1'b1, ihps_pkg::IHPS_PIO_RD, 1'b1, 8'h1);
    check(sel, 2'h2);
    check(o_drive_ctrl_block_select_oe, 1'b1);
    check(nrd, 1);
    check(o_rd_word, {1'b1, 16'hd000});
  endtask : pio_rd
  task automatic mw_rd;
    want <= 1'b0;
    run(1'b1, ihps_pkg::IHPS_MW_RD, 1'b0, 8'h3);
    check({sel, 8'(nrd)}, 10'h303);
    check(o_rd_word, {1'b1, 16'hd002});
  endtask : mw_rd
  task automatic mw_wr;
    run(1'b0, ihps_pkg::IHPS_MW_WR, 1'b0, 8'h2);
    check({dw, wd}, 24'h025a02);
  endtask : mw_wr
  task automatic ud_rd;
    fork
      run(1'b0, ihps_pkg::IHPS_UD_RD, 1'b0, 8'h4);
      begin
        repeat (40) @(posedge i_clk_sys);
        check(o_primary_read_strobe_n, 1'b0);
        repeat (5) @(posedge i_clk_sys);
        i_pause <= 1'b1;
        repeat (20) @(posedge i_clk_sys);
        check(o_primary_read_strobe_n, 1'b1);
        repeat (20) @(posedge i_clk_sys);
        i_pause <= 1'b0;
      end
    join
    check(nrd, 4);
    check(o_rd_word, {1'b0, 16'hd003});
  endtask : ud_rd
  task automatic ud_wr;
    run(1'b1, ihps_pkg::IHPS_UD_WR, 1'b0, 8'h3);
    check({dw, wd}, 24'h035a03);
  endtask : ud_wr
  initial begin
    do_reset(1'b1);
    want <= 1'b1;
    pio_wr;
    pio_rd;
    mw_rd;
    mw_wr;
    ud_rd;
    ud_wr;
    do_reset(1'b0);
    pio_wr;
    final_report;
  end
endmodule : ide_host_port_signaling_bench
`default_nettype wire

// ==== bench/ihps_drive_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ihps_drive_model (
  input wire logic i_clk,
  input wire logic i_chan,
  input wire logic [1:0] i_mode,
  input wire logic i_want,
  input wire logic [3:0] i_pins,
  input wire logic [15:0] i_dd,
  output logic [1:0] o_req,
  output logic o_rdy,
  output logic [15:0] o_dd,
  output logic [15:0] o_wd,
  output logic [7:0] o_wn
);
  // active channel: write strobe, read strobe, ack, all selects
  logic wr, rd, ak, cs, pwr, prd;
  logic [7:0] ix, tk, sk;
  assign {wr, rd, ak, cs} = i_pins;
  assign o_req = i_want ? {i_chan, !i_chan} : 2'h0;
  initial begin
    {pwr, prd, o_rdy} = 3'h7;
    {o_dd, o_wd, o_wn, ix, tk, sk} = '0;
  end
  always @(posedge i_clk) begin
    pwr <= wr;
    prd <= rd;
    tk <= ak ? 8'h0 : tk + 8'h1;
    sk <= (wr && rd) ? 8'h0 : sk + 8'h1;
    if (ak && cs)
      ix <= 8'h0;
    if (i_mode == 2'h0) begin
      // a slow drive: every strobe waits on ready first
      o_rdy <= (wr && rd) || sk > 8'h4;
      o_dd <= rd ? ~o_dd : 16'hd000 + {8'h0, ix};
      if (rd && !prd)
        ix <= ix + 8'h1;
      if (wr && !pwr) begin
        o_wd <= i_dd;
        o_wn <= o_wn + 8'h1;
      end
    end else if (i_mode == 2'h1) begin
      if (!ak && !rd && !wr && tk[1:0] == 2'h3) begin
        o_rdy <= ~o_rdy;
        o_dd <= 16'hd000 + {8'h0, ix};
        ix <= ix + 8'h1;
      end else if (ak)
        o_dd <= ~o_dd;
    end else begin
      o_rdy <= ak || (tk > 8'h2 && tk < 8'h7);
      o_dd <= ~o_dd;
      if (!ak && !wr && rd != prd) begin
        o_wd <= i_dd;
        o_wn <= o_wn + 8'h1;
      end
    end
  end
endmodule : ihps_drive_model
`default_nettype wire

// ==== bench/ihps_host_port_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module ihps_host_port_props (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_clk_link,
  input wire logic o_cmd_ready,
  input wire logic o_native_mode,
  input wire logic o_drive_cmd_block_select_n,
  input wire logic o_drive_ctrl_block_select_n,
  input wire logic o_drive_ctrl_block_select_oe,
  input wire logic i_drive_ctrl_block_select_n,
  input wire logic o_primary_write_strobe_n,
  input wire logic o_secondary_read_strobe_n,
  input wire logic i_primary_dma_request,
  input wire logic i_secondary_dma_request,
  input wire logic o_primary_dma_ack_n,
  input wire logic o_secondary_dma_ack_n,
  input wire logic i_channel_ready_in
);
  strap_mode_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(o_cmd_ready) && !o_drive_ctrl_block_select_oe
    |-> o_native_mode == $past(i_drive_ctrl_block_select_n, 3)) else $error("bad strap");
  // the ack decision reads the request from the second sync flop: three edges back here
  ack_p_req_a: assert property (@(posedge i_clk_link) disable iff (i_rst)
    $fell(o_primary_dma_ack_n) |-> $past(i_primary_dma_request, 3)) else $error("ack a");
  ack_s_req_a: assert property (@(posedge i_clk_link) disable iff (i_rst)
    $fell(o_secondary_dma_ack_n) |-> $past(i_secondary_dma_request, 3)) else $error("ack b");
  ack_apart_a: assert property (@(posedge i_clk_link) disable iff (i_rst)
    !o_primary_dma_ack_n |-> o_secondary_dma_ack_n) else $error("both acks");
  dma_no_sel_a: assert property (@(posedge i_clk_link) disable iff (i_rst)
    !o_primary_dma_ack_n || !o_secondary_dma_ack_n
    |-> o_drive_cmd_block_select_n && o_drive_ctrl_block_select_n) else $error("sel in dma");
  wr_qual_a: assert property (@(posedge i_clk_link) disable iff (i_rst)
    !o_primary_write_strobe_n |-> !o_drive_cmd_block_select_n
    || !o_drive_ctrl_block_select_n || !o_primary_dma_ack_n) else $error("bare write");
  rd_qual_a: assert property (@(posedge i_clk_link) disable iff (i_rst)
    !o_secondary_read_strobe_n |-> !o_drive_cmd_block_select_n
    || !o_drive_ctrl_block_select_n || !o_secondary_dma_ack_n) else $error("bare read");
  // the sync delays ready by two flops, so four low cycles pin the strobe low
  stretch_a: assert property (@(posedge i_clk_link) disable iff (i_rst)
    (!o_primary_write_strobe_n && !o_drive_cmd_block_select_n && !i_channel_ready_in) [*4]
    |=> !o_primary_write_strobe_n) else $error("no stretch");
endmodule : ihps_host_port_props
bind ihps_host_port ihps_host_port_props u_props (
  .i_clk_sys(i_clk_sys),
  .i_rst(i_rst),
  .i_clk_link(i_clk_link),
  .o_cmd_ready(o_cmd_ready),
  .o_native_mode(o_native_mode),
  .o_drive_cmd_block_select_n(o_drive_cmd_block_select_n),
  .o_drive_ctrl_block_select_n(o_drive_ctrl_block_select_n),
  .o_drive_ctrl_block_select_oe(o_drive_ctrl_block_select_oe),
  .i_drive_ctrl_block_select_n(i_drive_ctrl_block_select_n),
  .o_primary_write_strobe_n(o_primary_write_strobe_n),
  .o_secondary_read_strobe_n(o_secondary_read_strobe_n),
  .i_primary_dma_request(i_primary_dma_request),
  .i_secondary_dma_request(i_secondary_dma_request),
  .o_primary_dma_ack_n(o_primary_dma_ack_n),
  .o_secondary_dma_ack_n(o_secondary_dma_ack_n),
  .i_channel_ready_in(i_channel_ready_in)
);
`default_nettype wire

// ==== hw/ihps_defs.svh ====
`ifndef IHPS_DEFS_SVH
`define IHPS_DEFS_SVH

// data and word-count widths
`define IHPS_DATA_W 16
`define IHPS_CNT_W 8

// strobe timing in link clock cycles (setup, active, recovery)
`define IHPS_SETUP_CYC 4'h2
`define IHPS_ACTIVE_CYC 4'h3
`define IHPS_RECOVER_CYC 4'h2

// system clock cycles after reset release before the strap is taken
`define IHPS_STRAP_CYC 2'h3

`endif

// ==== hw/ihps_host_port.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "ihps_defs.svh"

module ihps_host_port (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_clk_link,
  input wire ihps_pkg::ihps_cmd_t i_cmd,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic i_pause,
  output logic o_done,
  output ihps_pkg::ihps_word_t o_rd_word,
  output logic o_rd_valid,
  output logic o_native_mode,
  output logic o_drive_cmd_block_select_n,
  output logic o_drive_ctrl_block_select_n,
  output logic o_drive_ctrl_block_select_oe,
  input wire logic i_drive_ctrl_block_select_n,
  output logic o_primary_write_strobe_n,
  output logic o_secondary_write_strobe_n,
  output logic o_primary_read_strobe_n,
  output logic o_secondary_read_strobe_n,
  input wire logic i_primary_dma_request,
  input wire logic i_secondary_dma_request,
  output logic o_primary_dma_ack_n,
  output logic o_secondary_dma_ack_n,
  input wire logic i_channel_ready_in,
  input wire logic [`IHPS_DATA_W-1:0] i_drive_data,
  output logic [`IHPS_DATA_W-1:0] o_drive_data,
  output logic o_drive_data_oe
);

  localparam int LSYNC_W = `IHPS_DATA_W + 6;

  typedef enum logic [2:0] {
    L_IDLE,
    L_ARM,
    L_SETUP,
    L_ACTIVE,
    L_RECOVER,
    L_UDMA,
    L_USTOP,
    L_FINISH
  } ihps_lstate_t;

  function automatic logic ihps_is_dma(input ihps_pkg::ihps_op_t op);
    ihps_is_dma = (op != ihps_pkg::IHPS_PIO_RD) && (op != ihps_pkg::IHPS_PIO_WR);
  endfunction : ihps_is_dma

  function automatic logic ihps_is_udma(input ihps_pkg::ihps_op_t op);
    ihps_is_udma = (op == ihps_pkg::IHPS_UD_RD) || (op == ihps_pkg::IHPS_UD_WR);
  endfunction : ihps_is_udma

  function automatic logic ihps_is_wr(input ihps_pkg::ihps_op_t op);
    ihps_is_wr = (op == ihps_pkg::IHPS_PIO_WR) || (op == ihps_pkg::IHPS_MW_WR)
                 || (op == ihps_pkg::IHPS_UD_WR);
  endfunction : ihps_is_wr

  // ---------------- system clock domain ----------------
  ihps_pkg::ihps_cmd_t cmd_q, next_cmd_q;
  logic cmd_tgl, next_cmd_tgl;
  logic busy, next_busy;
  logic done_seen, next_done_seen;
  logic res_seen, next_res_seen;
  logic [1:0] strap_cnt, next_strap_cnt;
  logic strap_done, next_strap_done;
  logic next_native_mode, next_cmd_ready, next_done, next_rd_valid;
  ihps_pkg::ihps_word_t next_rd_word;
  logic [2:0] s_sys;

  // ---------------- link clock domain ----------------
  ihps_lstate_t state, next_state;
  ihps_pkg::ihps_cmd_t cmd_l, next_cmd_l;
  logic [3:0] cnt, next_cnt;
  logic [`IHPS_CNT_W-1:0] words, next_words;
  logic cs0_n, next_cs0_n;
  logic cs1_n, next_cs1_n;
  logic cs1_oe, next_cs1_oe;
  logic [1:0] wr_n, next_wr_n;
  logic [1:0] rd_n, next_rd_n;
  logic [1:0] dack_n, next_dack_n;
  logic [`IHPS_DATA_W-1:0] dd_out, next_dd_out;
  logic dd_oe, next_dd_oe;
  ihps_pkg::ihps_word_t res_word, next_res_word;
  logic res_tgl, next_res_tgl;
  logic done_tgl, next_done_tgl;
  logic cmd_seen, next_cmd_seen;
  logic dstb_prev;
  logic [LSYNC_W-1:0] s_link;

  logic s_done_tgl, s_res_tgl, s_strap_pin;
  logic s_cmd_tgl, s_pause, s_strap_done, s_rdy;
  logic [1:0] s_drq;
  logic [`IHPS_DATA_W-1:0] s_dd;
  logic ch;

  ihps_sync #(.W(3)) u_sync_sys (
    .i_clk(i_clk_sys),
    .i_rst(i_rst),
    .i_d({done_tgl, res_tgl, i_drive_ctrl_block_select_n}),
    .o_q(s_sys)
  );

  ihps_sync #(.W(LSYNC_W)) u_sync_link (
    .i_clk(i_clk_link),
    .i_rst(i_rst),
    .i_d({cmd_tgl, i_pause, strap_done, i_secondary_dma_request,
          i_primary_dma_request, i_channel_ready_in, i_drive_data}),
    .o_q(s_link)
  );

  assign {s_done_tgl, s_res_tgl, s_strap_pin} = s_sys;
  assign {s_cmd_tgl, s_pause, s_strap_done, s_drq, s_rdy, s_dd} = s_link;
  assign ch = cmd_l.chan;

  always_comb begin
    next_cmd_q = cmd_q;
    next_cmd_tgl = cmd_tgl;
    next_busy = busy;
    next_done_seen = s_done_tgl;
    next_res_seen = s_res_tgl;
    next_strap_cnt = strap_cnt;
    next_strap_done = strap_done;
    next_native_mode = o_native_mode;
    next_done = 1'b0;
    next_rd_valid = 1'b0;
    next_rd_word = o_rd_word;
    // pin is still an input here: the link side keeps its enable low until done
    if (!strap_done) begin
      next_strap_cnt = strap_cnt + 2'h1;
      if (strap_cnt == `IHPS_STRAP_CYC) begin
        next_native_mode = s_strap_pin;
        next_strap_done = 1'b1;
      end
    end
    if (i_cmd_valid && o_cmd_ready) begin
      next_cmd_q = i_cmd;
      next_cmd_tgl = ~cmd_tgl;
      next_busy = 1'b1;
    end
    if (s_done_tgl != done_seen) begin
      next_busy = 1'b0;
      next_done = 1'b1;
    end
    // link word stays put for a full link cycle, so it is stable when sampled here
    if (s_res_tgl != res_seen) begin
      next_rd_word = res_word;
      next_rd_valid = 1'b1;
    end
    next_cmd_ready = !next_busy && next_strap_done;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cmd_q <= '0;
      cmd_tgl <= 1'b0;
      busy <= 1'b0;
      done_seen <= 1'b0;
      res_seen <= 1'b0;
      strap_cnt <= 2'h0;
      strap_done <= 1'b0;
      o_native_mode <= 1'b0;
      o_cmd_ready <= 1'b0;
      o_done <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_word <= '0;
    end else begin
      cmd_q <= next_cmd_q;
      cmd_tgl <= next_cmd_tgl;
      busy <= next_busy;
      done_seen <= next_done_seen;
      res_seen <= next_res_seen;
      strap_cnt <= next_strap_cnt;
      strap_done <= next_strap_done;
      o_native_mode <= next_native_mode;
      o_cmd_ready <= next_cmd_ready;
      o_done <= next_done;
      o_rd_valid <= next_rd_valid;
      o_rd_word <= next_rd_word;
    end
  end

  always_comb begin
    next_state = state;
    next_cmd_l = cmd_l;
    next_cnt = cnt;
    next_words = words;
    next_cs0_n = cs0_n;
    next_cs1_n = cs1_n;
    next_cs1_oe = s_strap_done;
    next_wr_n = wr_n;
    next_rd_n = rd_n;
    next_dack_n = dack_n;
    next_dd_out = dd_out;
    next_dd_oe = dd_oe;
    next_res_word = res_word;
    next_res_tgl = res_tgl;
    next_done_tgl = done_tgl;
    next_cmd_seen = cmd_seen;
    case (state)
      L_IDLE: begin
        if (s_cmd_tgl != cmd_seen) begin
          next_cmd_seen = s_cmd_tgl;
          next_cmd_l = cmd_q;
          next_words = '0;
          next_state = L_ARM;
        end
      end
      L_ARM: begin
        if (!ihps_is_dma(cmd_l.op)) begin
          if (cmd_l.ctrl_blk) begin
            next_cs1_n = 1'b0;
          end else begin
            next_cs0_n = 1'b0;
          end
          next_cnt = `IHPS_SETUP_CYC;
          next_state = L_SETUP;
        end else if (s_drq[ch]) begin
          next_dack_n[ch] = 1'b0;
          if (ihps_is_udma(cmd_l.op)) begin
            next_wr_n[ch] = 1'b0;
            next_rd_n[ch] = ihps_is_wr(cmd_l.op) ? 1'b1 : s_pause;
            next_state = L_UDMA;
          end else begin
            next_cnt = `IHPS_SETUP_CYC;
            next_state = L_SETUP;
          end
        end
      end
      L_SETUP: begin
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else begin
          if (ihps_is_wr(cmd_l.op)) begin
            next_wr_n[ch] = 1'b0;
            next_dd_out = cmd_l.wdata;
            next_dd_oe = 1'b1;
          end else begin
            next_rd_n[ch] = 1'b0;
          end
          next_cnt = `IHPS_ACTIVE_CYC;
          next_state = L_ACTIVE;
        end
      end
      L_ACTIVE: begin
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else if (s_rdy) begin
          next_wr_n[ch] = 1'b1;
          next_rd_n[ch] = 1'b1;
          if (!ihps_is_wr(cmd_l.op)) begin
            next_res_word = '{chan: ch, data: s_dd};
            next_res_tgl = ~res_tgl;
          end
          next_cnt = `IHPS_RECOVER_CYC;
          next_state = L_RECOVER;
        end
      end
      L_RECOVER: begin
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else begin
          next_dd_oe = 1'b0;
          next_words = words + 1'b1;
          // a multiword burst goes on only while the drive still requests
          if (ihps_is_dma(cmd_l.op) && (next_words < cmd_l.count) && s_drq[ch]) begin
            next_cnt = `IHPS_SETUP_CYC;
            next_state = L_SETUP;
          end else begin
            next_state = L_FINISH;
          end
        end
      end
      L_UDMA: begin
        if ((words >= cmd_l.count) || !s_drq[ch]) begin
          next_cnt = `IHPS_RECOVER_CYC;
          next_state = L_USTOP;
        end else if (ihps_is_wr(cmd_l.op)) begin
          next_dd_oe = 1'b1;
          if (!s_rdy) begin
            next_dd_out = cmd_l.wdata;
            next_rd_n[ch] = ~rd_n[ch];
            next_words = words + 1'b1;
          end
        end else begin
          next_rd_n[ch] = s_pause;
          if (s_rdy != dstb_prev) begin
            next_res_word = '{chan: ch, data: s_dd};
            next_res_tgl = ~res_tgl;
            next_words = words + 1'b1;
          end
        end
      end
      L_USTOP: begin
        next_wr_n[ch] = 1'b1;
        next_dd_oe = 1'b0;
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else begin
          next_state = L_FINISH;
        end
      end
      L_FINISH: begin
        next_cs0_n = 1'b1;
        next_cs1_n = 1'b1;
        next_wr_n = 2'b11;
        next_rd_n = 2'b11;
        next_dack_n = 2'b11;
        next_dd_oe = 1'b0;
        next_done_tgl = ~done_tgl;
        next_state = L_IDLE;
      end
      default: begin
        next_state = L_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_link or posedge i_rst) begin
    if (i_rst) begin
      state <= L_IDLE;
      cmd_l <= '0;
      cnt <= 4'h0;
      words <= '0;
      cs0_n <= 1'b1;
      cs1_n <= 1'b1;
      cs1_oe <= 1'b0;
      wr_n <= 2'b11;
      rd_n <= 2'b11;
      dack_n <= 2'b11;
      dd_out <= '0;
      dd_oe <= 1'b0;
      res_word <= '0;
      res_tgl <= 1'b0;
      done_tgl <= 1'b0;
      cmd_seen <= 1'b0;
      dstb_prev <= 1'b0;
    end else begin
      state <= next_state;
      cmd_l <= next_cmd_l;
      cnt <= next_cnt;
      words <= next_words;
      cs0_n <= next_cs0_n;
      cs1_n <= next_cs1_n;
      cs1_oe <= next_cs1_oe;
      wr_n <= next_wr_n;
      rd_n <= next_rd_n;
      dack_n <= next_dack_n;
      dd_out <= next_dd_out;
      dd_oe <= next_dd_oe;
      res_word <= next_res_word;
      res_tgl <= next_res_tgl;
      done_tgl <= next_done_tgl;
      cmd_seen <= next_cmd_seen;
      dstb_prev <= s_rdy;
    end
  end

  assign o_drive_cmd_block_select_n = cs0_n;
  assign o_drive_ctrl_block_select_n = cs1_n;
  assign o_drive_ctrl_block_select_oe = cs1_oe;
  assign o_primary_write_strobe_n = wr_n[0];
  assign o_secondary_write_strobe_n = wr_n[1];
  assign o_primary_read_strobe_n = rd_n[0];
  assign o_secondary_read_strobe_n = rd_n[1];
  assign o_primary_dma_ack_n = dack_n[0];
  assign o_secondary_dma_ack_n = dack_n[1];
  assign o_drive_data = dd_out;
  assign o_drive_data_oe = dd_oe;

endmodule : ihps_host_port

`default_nettype wire

// ==== hw/ihps_pkg.sv ====
`include "ihps_defs.svh"

package ihps_pkg;

  typedef enum logic [2:0] {
    IHPS_PIO_RD,
    IHPS_PIO_WR,
    IHPS_MW_RD,
    IHPS_MW_WR,
    IHPS_UD_RD,
    IHPS_UD_WR
  } ihps_op_t;

  typedef struct packed {
    logic chan;
    ihps_op_t op;
    logic ctrl_blk;
    logic [`IHPS_CNT_W-1:0] count;
    logic [`IHPS_DATA_W-1:0] wdata;
  } ihps_cmd_t;

  typedef struct packed {
    logic chan;
    logic [`IHPS_DATA_W-1:0] data;
  } ihps_word_t;

endpackage : ihps_pkg

// ==== hw/ihps_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module ihps_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  // first stage is read only by the second stage
  logic [W-1:0] meta;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= '0;
      o_q <= '0;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end

endmodule : ihps_sync

`default_nettype wire
